// [include/lbh_pkg.sv]
// package for the local bus host port: pin widths, lane codes, timing counts
// assumes a single 200 MHz clock and a host that drives its strobes synchronously
//
// Behaviour
// - the boot rom select pin level is caught when the filtered reset ends, high meaning local bus.
// - in local bus operation the boot rom select is driven low while memory read is low in rom range.
// - i/o addresses decode only while the address qualifier is low, and the host model holds it high between accesses.
// - the device may pull the open-drain cycle ready line low to lengthen a host access.
// - the 16-bit host data lines are driven only during decoded host reads.
// - the reset input is active high and assertions shorter than 100 ns are ignored.
// - address lines and upper byte enable are held from the falling edge of the latch strobe.
// - the interrupt request goes to exactly one of four outputs chosen by a two-bit select.
// - the selected interrupt output is active high and all unselected outputs float.
// - in 16-bit mode wide cycle select is pulled low when qualified address bits 15..4 match the base.

package lbh_pkg;

   // =====================================================================
   // pin and field widths
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned ADDR_LOW_W   = 10;   // address lines 0..9
   localparam int unsigned ADDR_MID_W   = 2;    // address lines 10..11
   localparam int unsigned ADDR_HIGH_W  = 7;    // address lines 12..18
   localparam int unsigned ADDR_W       = 20;   // whole address 0..19
   localparam int unsigned IO_BASE_W    = 12;   // compared with address 15..4
   localparam int unsigned IO_BASE_LSB  = 4;
   localparam int unsigned IO_BASE_MSB  = 15;
   localparam int unsigned ROM_BASE_W   = 6;    // compared with address 19..14
   localparam int unsigned ROM_BASE_LSB = 14;
   localparam int unsigned REG_INDEX_W  = 4;    // sixteen i/o locations
   localparam int unsigned IRQ_LINES    = 4;
   localparam int unsigned IRQ_SEL_W    = 2;

   // =====================================================================
   // byte lane enables, bit 1 is the upper byte
   localparam logic [1:0] LANES_BOTH  = 2'h3;
   localparam logic [1:0] LANES_LOW   = 2'h1;
   localparam logic [1:0] LANES_HIGH  = 2'h2;

   // =====================================================================
   // reset values
   localparam logic       LOCAL_BUS_RESET = 1'b1;   // open pin pulls up
   localparam logic [7:0] ZERO_BYTE       = 8'h00;

   // =====================================================================
   // timing: shortest reset pulse that counts, rounded up to whole cycles
   localparam int unsigned CLOCK_PERIOD_PS  = 5000;
   localparam int unsigned RESET_MIN_NS     = 100;
   localparam int unsigned RESET_MIN_CYCLES =
      (RESET_MIN_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // =====================================================================
   // host access states, one-hot
   typedef enum logic [2:0] {
      LBH_IDLE  = 3'b001,
      LBH_READ  = 3'b010,
      LBH_WRITE = 3'b100
   } lbh_access_e;

endpackage : lbh_pkg

// [src/lbh_host_port.sv]
// host side local bus port: decode, strobes, data lanes, wait, rom select, interrupts
// assumes host pins already synchronous to clock; the register core sits on the user side
`timescale 1ns/10ps
`default_nettype none

module lbh_host_port #(
   parameter int unsigned RESET_FILTER_CYCLES = lbh_pkg::RESET_MIN_CYCLES
) (
   input  wire  logic                              clock,
   input  wire  logic                              rst_n,
   // host pins
   input  wire  logic                              reset_in,
   input  wire  logic [lbh_pkg::ADDR_LOW_W-1:0]    host_address_low,
   input  wire  logic [lbh_pkg::ADDR_MID_W-1:0]    host_address_mid,
   input  wire  logic [lbh_pkg::ADDR_HIGH_W-1:0]   host_address_high,
   input  wire  logic                              host_address_top,
   input  wire  logic                              address_qualifier,
   input  wire  logic                              address_latch_strobe,
   input  wire  logic                              upper_byte_enable_n,
   input  wire  logic                              io_read_strobe_n,
   input  wire  logic                              io_write_strobe_n,
   input  wire  logic                              memory_read_strobe_n,
   input  wire  logic [lbh_pkg::DATA_W-1:0]        host_data_lines_in,
   output var   logic [lbh_pkg::DATA_W-1:0]        host_data_lines_out,
   output var   logic                              host_data_lines_oe_n,
   input  wire  logic                              boot_rom_select_n_in,
   output var   logic                              boot_rom_select_n_out,
   output var   logic                              boot_rom_select_n_oe_n,
   output var   logic                              cycle_ready_out,
   output var   logic                              cycle_ready_oe_n,
   output var   logic                              wide_cycle_select_n,
   output var   logic                              wide_cycle_select_oe_n,
   output var   logic                              interrupt_out_a,
   output var   logic                              interrupt_out_a_oe_n,
   output var   logic                              interrupt_out_b,
   output var   logic                              interrupt_out_b_oe_n,
   output var   logic                              interrupt_out_c,
   output var   logic                              interrupt_out_c_oe_n,
   output var   logic                              interrupt_out_d,
   output var   logic                              interrupt_out_d_oe_n,
   // register core side
   input  wire  logic [lbh_pkg::IO_BASE_W-1:0]     io_base_address,
   input  wire  logic [lbh_pkg::ROM_BASE_W-1:0]    rom_base_address,
   input  wire  logic                              wide_mode,
   input  wire  logic [lbh_pkg::IRQ_SEL_W-1:0]     interrupt_line_select,
   input  wire  logic                              interrupt_request,
   input  wire  logic                              reg_wait,
   input  wire  logic [lbh_pkg::DATA_W-1:0]        reg_read_data,
   output var   logic [lbh_pkg::REG_INDEX_W-1:0]   reg_index,
   output var   logic [1:0]                        reg_byte_enable,
   output var   logic                              reg_read,
   output var   logic                              reg_write,
   output var   logic [lbh_pkg::DATA_W-1:0]        reg_write_data,
   output var   logic                              core_reset,
   output var   logic                              local_bus_mode
);
   import lbh_pkg::*;

   localparam int unsigned CNT_W = $clog2(RESET_FILTER_CYCLES + 1);

   // =====================================================================
   // elaboration checks
   if (RESET_FILTER_CYCLES < 1) begin : g_bad_filter
      $error("reset filter needs at least one cycle");
   end

   // lane choice from address bit zero and upper byte enable
   function automatic logic [1:0] lanes_of(input logic a0, input logic ube_n);
      logic [1:0] l;
      l = LANES_BOTH;
      case ({a0, ube_n})
         2'b00:   l = LANES_BOTH;
         2'b01:   l = LANES_LOW;
         2'b10:   l = LANES_HIGH;
         2'b11:   l = LANES_HIGH;      // odd byte of an 8-bit host, sent on low lane
         default: l = LANES_BOTH;
      endcase
      return l;
   endfunction : lanes_of

   // =====================================================================
   // reset glitch filter
   logic [CNT_W-1:0] reset_count;
   logic             reset_prev;

   // reset must stay high for the full count; any drop restarts it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_count <= '0;
         core_reset  <= 1'b1;
      end else if (!reset_in) begin
         reset_count <= '0;
         core_reset  <= 1'b0;
      end else if (reset_count == CNT_W'(RESET_FILTER_CYCLES - 1)) begin
         core_reset  <= 1'b1;
      end else begin
         reset_count <= reset_count + 1'b1;
      end
   end

   // catch the strap level as the filtered reset falls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_prev     <= 1'b1;
         local_bus_mode <= LOCAL_BUS_RESET;
      end else begin
         reset_prev <= core_reset;
         if (reset_prev && !core_reset) begin
            local_bus_mode <= boot_rom_select_n_in;
         end
      end
   end

   // =====================================================================
   // address latch: transparent while the strobe is high, holds from its fall
   logic [ADDR_W-1:0] addr_hold;
   logic              ube_hold;
   logic [ADDR_W-1:0] addr_live;

   assign addr_live = {host_address_top, host_address_high, host_address_mid, host_address_low};

   // hosts without latching leave the strobe pulled high, so this just tracks
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_hold <= '0;
         ube_hold  <= 1'b1;
      end else if (address_latch_strobe) begin
         addr_hold <= addr_live;
         ube_hold  <= upper_byte_enable_n;
      end
   end

   // =====================================================================
   // decode
   logic io_hit;
   logic rom_hit;

   assign io_hit  = !address_qualifier
                    && addr_hold[IO_BASE_MSB:IO_BASE_LSB] == io_base_address;
   assign rom_hit = addr_hold[ADDR_W-1:ROM_BASE_LSB] == rom_base_address;

   // =====================================================================
   // access state machine
   lbh_access_e state;
   lbh_access_e next_state;
   logic [1:0]  lanes;

   assign lanes = lanes_of(addr_hold[0], ube_hold);

   // a strobe is honoured only while the decode hits; one strobe at a time
   always_comb begin
      next_state = state;
      case (state)
         LBH_IDLE: begin
            if (io_hit && !core_reset && !io_read_strobe_n && io_write_strobe_n) begin
               next_state = LBH_READ;
            end else if (io_hit && !core_reset && !io_write_strobe_n && io_read_strobe_n) begin
               next_state = LBH_WRITE;
            end
         end
         LBH_READ: begin
            if (io_read_strobe_n || !io_hit) begin
               next_state = LBH_IDLE;
            end
         end
         LBH_WRITE: begin
            if (io_write_strobe_n || !io_hit) begin
               next_state = LBH_IDLE;
            end
         end
         default: next_state = LBH_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= LBH_IDLE;
      end else if (core_reset) begin
         state <= LBH_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // core strobes: read pulses at entry, write pulses when the strobe lifts
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_read        <= 1'b0;
         reg_write       <= 1'b0;
         reg_index       <= '0;
         reg_byte_enable <= '0;
         reg_write_data  <= '0;
      end else begin
         reg_read  <= state == LBH_IDLE && next_state == LBH_READ && !core_reset;
         reg_write <= state == LBH_WRITE && next_state == LBH_IDLE && !core_reset;
         if (state == LBH_IDLE) begin
            reg_index       <= addr_hold[REG_INDEX_W-1:0];
            reg_byte_enable <= lanes;
         end
         // last data seen with the strobe low is what gets written
         if (state == LBH_WRITE && !io_write_strobe_n) begin
            if (addr_hold[0] && ube_hold) begin
               reg_write_data <= {host_data_lines_in[7:0], host_data_lines_in[7:0]};
            end else begin
               reg_write_data <= host_data_lines_in;
            end
         end
      end
   end

   // =====================================================================
   // data path out, wait line, wide select
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         host_data_lines_out    <= '0;
         host_data_lines_oe_n   <= 1'b1;
         cycle_ready_out        <= 1'b0;
         cycle_ready_oe_n       <= 1'b1;
         wide_cycle_select_n    <= 1'b0;
         wide_cycle_select_oe_n <= 1'b1;
      end else begin
         // an odd byte for an 8-bit host comes back on the low lane
         if (addr_hold[0] && ube_hold) begin
            host_data_lines_out <= {ZERO_BYTE, reg_read_data[15:8]};
         end else begin
            host_data_lines_out <= reg_read_data;
         end
         host_data_lines_oe_n   <= !(state == LBH_READ && next_state == LBH_READ);
         // released unless the core asks for more time inside an access
         cycle_ready_oe_n       <= !(state != LBH_IDLE && next_state != LBH_IDLE
                                     && reg_wait);
         wide_cycle_select_oe_n <= !(wide_mode && io_hit && !core_reset);
      end
   end

   // =====================================================================
   // boot rom chip select
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_rom_select_n_out  <= 1'b1;
         boot_rom_select_n_oe_n <= 1'b1;
      end else begin
         // pin must float in reset so the strap can be read
         boot_rom_select_n_oe_n <= !(local_bus_mode && !core_reset);
         boot_rom_select_n_out  <= !(!memory_read_strobe_n && rom_hit);
      end
   end

   // =====================================================================
   // interrupt routing
   logic [IRQ_LINES-1:0] irq_level;
   logic [IRQ_LINES-1:0] irq_oe_n;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_level <= '0;
         irq_oe_n  <= '1;
      end else begin
         for (int i = 0; i < IRQ_LINES; i++) begin
            irq_level[i] <= interrupt_request && !core_reset;
            irq_oe_n[i]  <= interrupt_line_select != IRQ_SEL_W'(i);
         end
      end
   end

   assign interrupt_out_a      = irq_level[0];
   assign interrupt_out_b      = irq_level[1];
   assign interrupt_out_c      = irq_level[2];
   assign interrupt_out_d      = irq_level[3];
   assign interrupt_out_a_oe_n = irq_oe_n[0];
   assign interrupt_out_b_oe_n = irq_oe_n[1];
   assign interrupt_out_c_oe_n = irq_oe_n[2];
   assign interrupt_out_d_oe_n = irq_oe_n[3];

endmodule : lbh_host_port

`default_nettype wire

// [bench/lbh_props.sv]
// checker for the local bus host port: pin relations over time
// assumes lbh_host_port with one clock and host pins synchronous to it
`timescale 1ns/10ps
`default_nettype none
module lbh_props #(parameter int unsigned RESET_FILTER_CYCLES = 20) (
   input wire logic       clock, rst_n, reset_in, io_read_strobe_n, io_write_strobe_n,
   input wire logic       memory_read_strobe_n, host_address_top, interrupt_request,
   input wire logic       reg_wait, boot_rom_select_n_in, address_latch_strobe,
   input wire logic [6:0] host_address_high,
   input wire logic [5:0] rom_base_address,
   input wire logic [1:0] interrupt_line_select,
   input wire logic       host_data_lines_oe_n, boot_rom_select_n_out, boot_rom_select_n_oe_n,
   input wire logic       cycle_ready_oe_n, interrupt_out_a, interrupt_out_b, interrupt_out_c,
   input wire logic       interrupt_out_d, interrupt_out_a_oe_n, interrupt_out_b_oe_n,
   input wire logic       interrupt_out_c_oe_n, interrupt_out_d_oe_n,
   input wire logic       reg_read, reg_write, core_reset, local_bus_mode
);
   // =====================================================================
   // helpers
   int unsigned hi_cnt;
   logic [3:0]  irq, irq_oe_n;
   assign irq = {interrupt_out_d, interrupt_out_c, interrupt_out_b, interrupt_out_a};
   assign irq_oe_n = {interrupt_out_d_oe_n, interrupt_out_c_oe_n,
                      interrupt_out_b_oe_n, interrupt_out_a_oe_n};
   // consecutive high samples of the reset pin, saturating so it never wraps
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) hi_cnt <= 0;
      else if (!reset_in) hi_cnt <= 0;
      else if (hi_cnt < 255) hi_cnt <= hi_cnt + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // the decode sees the address one cycle late, through the transparent latch
   sequence rom_hit_s;
      address_latch_strobe && {host_address_top, host_address_high[6:2]} == rom_base_address
      ##1 !memory_read_strobe_n && local_bus_mode && !core_reset
      && {host_address_top, host_address_high[6:2]} == rom_base_address;
   endsequence
   // the data bus turns on one cycle after the read pulse
   sequence read_pulse_s;
      reg_read ##1 !reg_read && !host_data_lines_oe_n;
   endsequence
   // =====================================================================
   // assertions
   chk_reset_filter: assert property ($rose(core_reset) |-> hi_cnt >= RESET_FILTER_CYCLES)
      else $error("core reset rose before the filter count");
   chk_reset_drop: assert property (!reset_in |=> !core_reset)
      else $error("core reset held after reset pin low");
   chk_read_drive: assert property (!host_data_lines_oe_n |-> $past(!io_read_strobe_n))
      else $error("data bus driven without read strobe");
   chk_read_start: assert property ($rose(reg_read) |-> $past(!io_read_strobe_n) ##0 read_pulse_s)
      else $error("read pulse malformed");
   chk_write_pulse: assert property (reg_write |-> $past(io_write_strobe_n)
      && !$past(io_write_strobe_n, 2) ##1 !reg_write)
      else $error("write pulse not after strobe release");
   chk_wait_cause: assert property (!cycle_ready_oe_n |-> $past(reg_wait))
      else $error("cycle ready pulled without wait request");
   chk_rom_select: assert property (rom_hit_s |=> !boot_rom_select_n_out && !boot_rom_select_n_oe_n)
      else $error("rom select not asserted");
   chk_irq_route: assert property (!$past(core_reset) |-> irq_oe_n == ~(4'h1 << $past(interrupt_line_select))
      && irq[$past(interrupt_line_select)] == $past(interrupt_request))
      else $error("interrupt routing wrong");
   chk_strap_catch: assert property ($fell(core_reset) |=> local_bus_mode == $past(boot_rom_select_n_in))
      else $error("strap not caught");
endmodule : lbh_props
bind lbh_host_port lbh_props #(.RESET_FILTER_CYCLES(RESET_FILTER_CYCLES)) lbh_props_i (.*);
`default_nettype wire

// [bench/lbh_host_model.sv]
// host processor model: drives address, qualifier, latch and strobes
// assumes weak pull-ups on data, rom select and cycle ready wires
`timescale 1ns/10ps
`default_nettype none
module lbh_host_model (
   input  wire logic        clock, host_data_lines_oe_n, cycle_ready_out, cycle_ready_oe_n,
   input  wire logic        boot_rom_select_n_out, boot_rom_select_n_oe_n,
   input  wire logic [15:0] host_data_lines_out,
   output var  logic [19:0] addr,
   output var  logic        address_qualifier, address_latch_strobe, upper_byte_enable_n,
   output var  logic        io_read_strobe_n, io_write_strobe_n, memory_read_strobe_n,
   output wire logic [15:0] host_data_lines_in,
   output wire logic        ready, boot_rom_select_n_in
);
   logic        drive;
   logic [15:0] wdata;
   // released wires float to their pull-up level
   assign host_data_lines_in = !host_data_lines_oe_n ? host_data_lines_out : drive ? wdata : 16'hFFFF;
   assign ready = cycle_ready_oe_n | cycle_ready_out;
   assign boot_rom_select_n_in = boot_rom_select_n_oe_n | boot_rom_select_n_out;
   initial begin
      {addr, drive, wdata} = '0;
      {address_qualifier, address_latch_strobe, upper_byte_enable_n} = 3'h7;
      {io_read_strobe_n, io_write_strobe_n, memory_read_strobe_n} = 3'h7;
   end
   // =====================================================================
   // one i/o access; lat freezes the address then scrambles the pins
   task automatic io(input logic wr, lat, aq, input logic [19:0] a, input logic ube,
                     input logic [15:0] d, output logic [15:0] q, output logic ok);
      int n;
      @(negedge clock);
      addr = a;
      upper_byte_enable_n = ube;
      address_qualifier = aq;
      drive = wr;
      wdata = d;
      if (lat) begin
         repeat (2) @(negedge clock);
         address_latch_strobe = 1'b0;
         addr = ~a;
         upper_byte_enable_n = ~ube;
      end
      repeat (2) @(negedge clock);
      if (wr) io_write_strobe_n = 1'b0;
      else io_read_strobe_n = 1'b0;
      repeat (3) @(negedge clock);
      n = 0;
      // hold the strobe until the device lets go of cycle ready
      while (ready === 1'b0 && n < 100) begin
         @(negedge clock);
         n++;
      end
      q = host_data_lines_in;
      ok = n < 100;
      @(negedge clock);
      {io_read_strobe_n, io_write_strobe_n, address_qualifier, address_latch_strobe} = 4'hF;
      drive = 1'b0;
      repeat (3) @(negedge clock);
   endtask : io
   // boot rom fetch, returns the rom select wire level
   task automatic rom(input logic [19:0] a, output logic sel);
      @(negedge clock);
      addr = a;
      memory_read_strobe_n = 1'b0;
      repeat (3) @(negedge clock);
      sel = boot_rom_select_n_in;
      memory_read_strobe_n = 1'b1;
   endtask : rom
endmodule : lbh_host_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for lbh_host_port with the host model on its pins
// assumes the register core side is driven here directly
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lbh_pkg::*;
   localparam int unsigned FILT = 20;
   logic clock = 1'b0, rst_n = 1'b0, reset_in = 1'b0, wide_mode = 1'b1, ok;
   logic interrupt_request = 1'b0, reg_wait = 1'b0;
   logic [11:0] io_base_address = 12'h030;
   logic [5:0]  rom_base_address = 6'h33;
   logic [1:0]  interrupt_line_select = 2'h0, reg_byte_enable;
   logic [15:0] reg_read_data = 16'h0000, host_data_lines_in, host_data_lines_out, reg_write_data;
   logic [19:0] addr;
   logic [3:0]  reg_index, irq, irq_oe_n;
   logic [22:0] nt, notes[$];
   logic [31:0] seed = 32'h0000_0043;
   wire logic [9:0] host_address_low = addr[9:0];
   wire logic [1:0] host_address_mid = addr[11:10];
   wire logic [6:0] host_address_high = addr[18:12];
   wire logic       host_address_top = addr[19];
   logic address_qualifier, address_latch_strobe, upper_byte_enable_n, io_read_strobe_n;
   logic io_write_strobe_n, memory_read_strobe_n, ready, host_data_lines_oe_n, core_reset;
   logic boot_rom_select_n_in, boot_rom_select_n_out, boot_rom_select_n_oe_n, local_bus_mode;
   logic cycle_ready_out, cycle_ready_oe_n, wide_cycle_select_n, wide_cycle_select_oe_n;
   logic interrupt_out_a, interrupt_out_b, interrupt_out_c, interrupt_out_d, reg_read, reg_write;
   logic interrupt_out_a_oe_n, interrupt_out_b_oe_n, interrupt_out_c_oe_n, interrupt_out_d_oe_n;
   int errors = 0, total_checks = 0, wcnt = 0;
   assign irq = {interrupt_out_d, interrupt_out_c, interrupt_out_b, interrupt_out_a};
   assign irq_oe_n = {interrupt_out_d_oe_n, interrupt_out_c_oe_n,
                      interrupt_out_b_oe_n, interrupt_out_a_oe_n};
   lbh_host_port #(.RESET_FILTER_CYCLES(FILT)) lbh_host_port_i (.*);
   lbh_host_model lbh_host_model_i (.*);
   always #2.5 clock = ~clock;
   // =====================================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   // the core releases its wait after four stretched cycles
   always @(negedge clock) begin
      wcnt <= cycle_ready_oe_n === 1'b0 ? wcnt + 1 : 0;
      if (wcnt == 3) reg_wait <= 1'b0;
   end
   // scoreboard: each core strobe matches the oldest note
   always @(negedge clock) begin
      if (rst_n && (reg_read === 1'b1 || reg_write === 1'b1)) begin
         if (notes.size() == 0) check(1, 0);
         else begin
            nt = notes.pop_front();
            check({reg_write, reg_index, reg_byte_enable, reg_write_data & {16{reg_write}}
               & {{8{reg_byte_enable[1]}}, {8{reg_byte_enable[0]}}}}, nt);
         end
         if (reg_read === 1'b1) check({wide_cycle_select_oe_n, wide_cycle_select_n}, {!wide_mode, 1'b0});
      end
   end
   // =====================================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] q, d, hm;
      logic [1:0]  c, ln;
      logic [3:0]  ix;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      check(local_bus_mode, 1'b1);
      reset_in = 1'b1;
      repeat (FILT - 1) @(negedge clock);
      reset_in = 1'b0;
      @(negedge clock);
      check(core_reset, 1'b0);
      reset_in = 1'b1;
      repeat (FILT + 3) @(negedge clock);
      check(core_reset, 1'b1);
      reset_in = 1'b0;
      repeat (5) @(negedge clock);
      check({core_reset, local_bus_mode}, 2'h1);
      $display("test reset filter done");
      // every lane case, read and write, with random waits and one latched address
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         c = i[2:1];
         wide_mode = i < 4;
         reg_wait = r[4];
         reg_read_data = r[31:16];
         d = r[15:0];
         ix = {r[7:5], c[1]};
         ln = c == 0 ? 2'h3 : c == 1 ? LANES_LOW : LANES_HIGH;
         hm = ln == 3 ? 16'hFFFF : (c == 2 ? 16'hFF00 : 16'h00FF);
         if (i[0]) notes.push_back({1'b1, ix, ln, c == 3 ? {d[7:0], 8'h00} : d & ~hm ^ d});
         else notes.push_back({1'b0, ix, ln, 16'h0000});
         lbh_host_model_i.io(i[0], i == 5, 1'b0, {16'h0030, ix}, c[0], d, q, ok);
         check(ok, 1'b1);
         if (ok !== 1'b1) final_report();
         if (!i[0]) check(q & hm, (c == 3 ? {8'h00, r[31:24]} : r[31:16]) & hm);
      end
      $display("test lanes and waits done");
      // refused: qualifier high at a hit, then a miss with qualifier low
      reg_wait = 1'b1;
      for (int i = 0; i < 2; i++) begin
         lbh_host_model_i.io(1'b0, 1'b0, !i[0], i ? 20'h0_0400 : 20'h0_0305, 1'b0, 16'h0000, q, ok);
         check({q, ok}, {16'hFFFF, 1'b1});
      end
      check(notes.size(), 0);
      reg_wait = 1'b0;
      $display("test refused access done");
      lbh_host_model_i.rom(20'hC_C123, ok);
      check(ok, 1'b0);
      lbh_host_model_i.rom(20'h4_4123, ok);
      check(ok, 1'b1);
      $display("test boot rom select done");
      for (int s = 0; s < 4; s++) begin
         interrupt_line_select = s[1:0];
         interrupt_request = 1'b1;
         repeat (2) @(negedge clock);
         check({irq_oe_n, irq[s]}, {~(4'h1 << s), 1'b1});
         interrupt_request = 1'b0;
         repeat (2) @(negedge clock);
         check(irq[s], 1'b0);
      end
      $display("test interrupt routing done");
      final_report();
   end
endmodule : testbench
`default_nettype wire
